/* srcr_pkg.sv */
// Constants shared by the sensor readout control register bank
package srcr_pkg;

  typedef enum logic [1:0] {CLS_IMM, CLS_STBY, CLS_FRAME} srcr_class_e;

  localparam int NUM_REGS = 36;

  // Byte register indices
  localparam int IX_STBY = 0, IX_HOLD = 1, IX_MSTOP = 2, IX_ROLE = 3;
  localparam int IX_WAIT1L = 4, IX_WAIT1H = 5, IX_WAIT2L = 6, IX_WAIT2H = 7;
  localparam int IX_WIN = 8, IX_HBIN = 9, IX_VBIN = 10, IX_ADDM = 11;
  localparam int IX_VMAX0 = 12, IX_VMAX1 = 13, IX_VMAX2 = 14;
  localparam int IX_HMAXL = 15, IX_HMAXH = 16, IX_INV = 17;
  localparam int IX_ADC = 18, IX_OWID = 19, IX_RATE = 20;
  localparam int IX_HSTL = 21, IX_HSTH = 22, IX_HWDL = 23, IX_HWDH = 24;
  localparam int IX_VSTL = 25, IX_VSTH = 26, IX_VHTL = 27, IX_VHTH = 28;
  localparam int IX_STORAGE_TIME = 29, IX_SHR1 = 30, IX_SHR2 = 31;
  localparam int IX_GAINL = 32, IX_GAINH = 33, IX_SYFN = 34, IX_SYDRV = 35;

  localparam logic [15:0] REG_ADDR [NUM_REGS] = '{
    16'h3000, 16'h3001, 16'h3002, 16'h3003, 16'h3008, 16'h3009, 16'h300a, 16'h300b,
    16'h301c, 16'h3020, 16'h3021, 16'h3022, 16'h3024, 16'h3025, 16'h3026,
    16'h3028, 16'h3029, 16'h3030, 16'h3031, 16'h3032, 16'h3033,
    16'h3040, 16'h3041, 16'h3042, 16'h3043, 16'h3044, 16'h3045, 16'h3046, 16'h3047,
    16'h3050, 16'h3051, 16'h3052, 16'h3090, 16'h3091, 16'h30c0, 16'h30c1};

  localparam logic [7:0] REG_RST [NUM_REGS] = '{
    8'h01, 8'h00, 8'h01, 8'h00, 8'hff, 8'h00, 8'hb6, 8'ha0,
    8'h00, 8'h00, 8'h00, 8'h00, 8'hca, 8'h08, 8'h00,
    8'h26, 8'h02, 8'h00, 8'h01, 8'h01, 8'h04,
    8'h00, 8'h00, 8'h18, 8'h0f, 8'h00, 8'h00, 8'h20, 8'h11,
    8'h66, 8'h00, 8'h00, 8'h00, 8'h00, 8'h2a, 8'h0f};

  // Writable bits; all other bits keep their fixed reset value
  localparam logic [7:0] REG_MASK [NUM_REGS] = '{
    8'h01, 8'h01, 8'h01, 8'h01, 8'hff, 8'h03, 8'hff, 8'h03,
    8'h0f, 8'h01, 8'h01, 8'h03, 8'hff, 8'hff, 8'h0f,
    8'hff, 8'hff, 8'h03, 8'h03, 8'h01, 8'h0f,
    8'hff, 8'h1f, 8'hff, 8'h1f, 8'hff, 8'h1f, 8'hff, 8'h1f,
    8'hff, 8'hff, 8'h0f, 8'hff, 8'h01, 8'h0f, 8'h0f};

  localparam srcr_class_e REG_CLASS [NUM_REGS] = '{
    CLS_IMM, CLS_IMM, CLS_IMM, CLS_STBY, CLS_STBY, CLS_STBY, CLS_STBY, CLS_STBY,
    CLS_FRAME, CLS_STBY, CLS_STBY, CLS_STBY, CLS_FRAME, CLS_FRAME, CLS_FRAME,
    CLS_FRAME, CLS_FRAME, CLS_FRAME, CLS_STBY, CLS_STBY, CLS_STBY,
    CLS_FRAME, CLS_FRAME, CLS_FRAME, CLS_FRAME, CLS_FRAME, CLS_FRAME, CLS_FRAME,
    CLS_FRAME, CLS_FRAME, CLS_FRAME, CLS_FRAME, CLS_FRAME, CLS_FRAME, CLS_IMM,
    CLS_STBY};

  // Field codes
  localparam logic [3:0] WIN_CROP = 4'h4;
  localparam logic [1:0] ADD_2X2 = 2'h1;
  localparam logic [1:0] ADC_12 = 2'h1;
  localparam logic [1:0] SYNC_FN_OUT = 2'h2;
  localparam logic [1:0] SYNC_DRV_OUT = 2'h0;
  localparam logic [8:0] GAIN_MAX = 9'h0f0;
  localparam logic [12:0] CROP_HW_STEP = 13'h0018;

  // Serial lane rate table
  localparam int NUM_RATES = 7;
  localparam logic [3:0] RATE_CODE [NUM_RATES] = '{
    4'h0, 4'h2, 4'h4, 4'h5, 4'h7, 4'h8, 4'h9};
  localparam logic [11:0] RATE_MBPS [NUM_RATES] = '{
    12'h948, 12'h81f, 12'h6f6, 12'h37b, 12'h252, 12'h5cd, 12'h2d0};

endpackage

/* srcr_byte_reg.sv */
// One control byte: written shadow copy and applied copy
`timescale 1ns/1ps
`default_nettype none
module srcr_byte_reg #(
  parameter logic [7:0] RST = 8'h00,
  parameter logic [7:0] MASK = 8'hff,
  parameter srcr_pkg::srcr_class_e CLS = srcr_pkg::CLS_IMM
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstN,
  // Write side
  input wire logic wrEn,
  input wire logic [7:0] wrData,
  // Apply events
  input wire logic stbyRelease,
  input wire logic frameApply,
  // Values
  output logic [7:0] shadow,
  output logic [7:0] active
);
  logic [7:0] shadow_next;
  logic [7:0] active_next;
  logic load;

  // Fixed bits never change, whatever is written
  assign shadow_next = wrEn ? ((wrData & MASK) | (RST & ~MASK)) : shadow;
  assign load = (CLS == srcr_pkg::CLS_IMM) ||
                ((CLS == srcr_pkg::CLS_STBY) && stbyRelease) ||
                ((CLS == srcr_pkg::CLS_FRAME) && frameApply);
  assign active_next = load ? shadow_next : active;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      shadow <= RST;
      active <= RST;
    end else begin
      shadow <= shadow_next;
      active <= active_next;
    end
  end
endmodule
`default_nettype wire

/* srcr_sync_pin.sv */
// Sync pin driver with function and drive selection
`timescale 1ns/1ps
`default_nettype none
module srcr_sync_pin (
  // Clock and reset
  input wire logic clk,
  input wire logic rstN,
  // Settings
  input wire logic master,
  input wire logic [1:0] pinFunction,
  input wire logic [1:0] pinDrive,
  // Timing generator level
  input wire logic genLevel,
  // Pin
  input wire logic pinIn,
  output logic pinOut,
  output logic pinOe,
  output logic pinSample
);
  logic pinOut_next;
  logic pinOe_next;

  assign pinOut_next = master && (pinFunction == srcr_pkg::SYNC_FN_OUT) && genLevel;
  assign pinOe_next = (pinDrive == srcr_pkg::SYNC_DRV_OUT);

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pinOut <= 1'b0;
      pinOe <= 1'b0;
      pinSample <= 1'b0;
    end else begin
      pinOut <= pinOut_next;
      pinOe <= pinOe_next;
      pinSample <= pinIn;
    end
  end
endmodule
`default_nettype wire

/* srcr_regs.sv */
// Control register bank of the sensor readout: registers, apply timing, decoded controls
`timescale 1ns/1ps
`default_nettype none
module srcr_regs (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Byte register port
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [15:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  output logic regRdValid,
  // Timing generator
  input wire logic frameReflect,
  input wire logic vsyncGen,
  input wire logic hsyncGen,
  // Sync pins
  input wire logic vsyncPinIn,
  output logic vsyncPinOut,
  output logic vsyncPinOe,
  output logic vsyncSample,
  input wire logic hsyncPinIn,
  output logic hsyncPinOut,
  output logic hsyncPinOe,
  output logic hsyncSample,
  // Operating state
  output logic standbyOn,
  output logic timingRun,
  output logic slaveMode,
  output logic [9:0] firstWaitTime,
  output logic [9:0] secondWaitTime,
  // Readout mode
  output logic cropEnable,
  output logic horizontalBinEnable,
  output logic verticalBinEnable,
  output logic binCombine2x2,
  output logic horizontalMirror,
  output logic verticalFlip,
  output logic cropParamError,
  // Frame geometry
  output logic [19:0] frameLineCount,
  output logic [15:0] lineClockCount,
  output logic [12:0] cropHorizontalStart,
  output logic [12:0] cropHorizontalWidth,
  output logic [12:0] cropVerticalStart,
  output logic [12:0] cropVerticalHeight,
  // Conversion and output
  output logic converter12Bit,
  output logic outputWord12Bit,
  output logic [3:0] serialRateSelect,
  output logic [11:0] laneRateMbps,
  output logic [19:0] storageTime,
  output logic [8:0] gainCode
);
  localparam int N = srcr_pkg::NUM_REGS;

  logic rstMetaN_reg;
  logic rstN_reg;
  logic [7:0] shByte [N];
  logic [7:0] actByte [N];
  logic [N-1:0] addrHit;
  logic stbyNow;
  logic stbyPrev_reg;
  logic stbyRelease;
  logic holdOn;
  logic frameApply;
  logic master;
  logic [7:0] rdMux;
  logic [11:0] rateMbps;
  logic rateKnown;
  logic [3:0] winMode;
  logic [1:0] bin_combine_mode;
  logic [1:0] adcDepth;
  logic [8:0] gainRaw;
  logic [12:0] hWidth;
  logic cropErr;

  logic standbyOn_next;
  logic timingRun_next;
  logic cropEnable_next;
  logic hBin_next;
  logic vBin_next;
  logic bin2x2_next;
  logic conv12_next;
  logic out12_next;
  logic [11:0] laneRate_next;
  logic [8:0] gain_next;
  logic cropErr_next;
  logic [7:0] rdData_next;

  // Reset release through two flops
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMetaN_reg <= 1'b0;
      rstN_reg <= 1'b0;
    end else begin
      rstMetaN_reg <= 1'b1;
      rstN_reg <= rstMetaN_reg;
    end
  end

  // Apply events
  assign stbyNow = shByte[srcr_pkg::IX_STBY][0];
  assign stbyRelease = stbyPrev_reg && !stbyNow;
  assign holdOn = actByte[srcr_pkg::IX_HOLD][0];
  assign frameApply = frameReflect && !holdOn;

  // Byte registers
  genvar gi;
  for (gi = 0; gi < N; gi++) begin : g_byte
    assign addrHit[gi] = (regAddr == srcr_pkg::REG_ADDR[gi]);
    srcr_byte_reg #(
      .RST(srcr_pkg::REG_RST[gi]),
      .MASK(srcr_pkg::REG_MASK[gi]),
      .CLS(srcr_pkg::REG_CLASS[gi])
    ) u_byte (
      .clk(core_clk),
      .rstN(rstN_reg),
      .wrEn(regWrEn && addrHit[gi]),
      .wrData(regWrData),
      .stbyRelease(stbyRelease),
      .frameApply(frameApply),
      .shadow(shByte[gi]),
      .active(actByte[gi])
    );
  end

  // Read back the written value; unmapped addresses read zero
  always_comb begin
    rdMux = 8'h00;
    for (int i = 0; i < N; i++) begin
      if (addrHit[i]) begin
        rdMux = shByte[i];
      end
    end
  end
  assign rdData_next = regRdEn ? rdMux : regRdData;

  // Field assembly, low address holds low bits
  assign firstWaitTime = {actByte[srcr_pkg::IX_WAIT1H][1:0], actByte[srcr_pkg::IX_WAIT1L]};
  assign secondWaitTime = {actByte[srcr_pkg::IX_WAIT2H][1:0], actByte[srcr_pkg::IX_WAIT2L]};
  assign frameLineCount = {actByte[srcr_pkg::IX_VMAX2][3:0], actByte[srcr_pkg::IX_VMAX1],
                           actByte[srcr_pkg::IX_VMAX0]};
  assign lineClockCount = {actByte[srcr_pkg::IX_HMAXH], actByte[srcr_pkg::IX_HMAXL]};
  assign cropHorizontalStart = {actByte[srcr_pkg::IX_HSTH][4:0], actByte[srcr_pkg::IX_HSTL]};
  assign hWidth = {actByte[srcr_pkg::IX_HWDH][4:0], actByte[srcr_pkg::IX_HWDL]};
  assign cropHorizontalWidth = hWidth;
  assign cropVerticalStart = {actByte[srcr_pkg::IX_VSTH][4:0], actByte[srcr_pkg::IX_VSTL]};
  assign cropVerticalHeight = {actByte[srcr_pkg::IX_VHTH][4:0], actByte[srcr_pkg::IX_VHTL]};
  assign storageTime = {actByte[srcr_pkg::IX_SHR2][3:0], actByte[srcr_pkg::IX_SHR1],
                        actByte[srcr_pkg::IX_STORAGE_TIME]};
  assign gainRaw = {actByte[srcr_pkg::IX_GAINH][0], actByte[srcr_pkg::IX_GAINL]};
  assign horizontalMirror = actByte[srcr_pkg::IX_INV][0];
  assign verticalFlip = actByte[srcr_pkg::IX_INV][1];
  assign serialRateSelect = actByte[srcr_pkg::IX_RATE][3:0];
  assign winMode = actByte[srcr_pkg::IX_WIN][3:0];
  assign bin_combine_mode = actByte[srcr_pkg::IX_ADDM][1:0];
  assign adcDepth = actByte[srcr_pkg::IX_ADC][1:0];
  assign master = !actByte[srcr_pkg::IX_ROLE][0];

  // Lane rate lookup; unlisted codes report zero
  always_comb begin
    rateMbps = 12'h000;
    rateKnown = 1'b0;
    for (int i = 0; i < srcr_pkg::NUM_RATES; i++) begin
      if (serialRateSelect == srcr_pkg::RATE_CODE[i]) begin
        rateMbps = srcr_pkg::RATE_MBPS[i];
        rateKnown = 1'b1;
      end
    end
  end

  // Crop values the timing cannot honour
  assign cropErr = cropHorizontalStart[0] ||
                   ((hWidth % srcr_pkg::CROP_HW_STEP) != 13'h0000) ||
                   (cropVerticalStart[1:0] != 2'h0) ||
                   (cropVerticalHeight[1:0] != 2'h0);

  // Decoded controls
  assign standbyOn_next = actByte[srcr_pkg::IX_STBY][0];
  assign timingRun_next = master && !actByte[srcr_pkg::IX_MSTOP][0] && !standbyOn_next;
  assign cropEnable_next = (winMode == srcr_pkg::WIN_CROP);
  assign hBin_next = actByte[srcr_pkg::IX_HBIN][0];
  assign vBin_next = actByte[srcr_pkg::IX_VBIN][0];
  assign bin2x2_next = (bin_combine_mode == srcr_pkg::ADD_2X2);
  assign conv12_next = (adcDepth == srcr_pkg::ADC_12);
  assign out12_next = actByte[srcr_pkg::IX_OWID][0];
  assign laneRate_next = rateKnown ? rateMbps : 12'h000;
  assign gain_next = (gainRaw > srcr_pkg::GAIN_MAX) ? srcr_pkg::GAIN_MAX : gainRaw;
  assign cropErr_next = cropEnable_next && cropErr;

  always_ff @(posedge core_clk or negedge rstN_reg) begin
    if (!rstN_reg) begin
      stbyPrev_reg <= 1'b1;
      regRdData <= 8'h00;
      regRdValid <= 1'b0;
    end else begin
      stbyPrev_reg <= stbyNow;
      regRdData <= rdData_next;
      regRdValid <= regRdEn;
    end
  end

  always_ff @(posedge core_clk or negedge rstN_reg) begin
    if (!rstN_reg) begin
      standbyOn <= 1'b1;
      timingRun <= 1'b0;
      slaveMode <= 1'b0;
      cropEnable <= 1'b0;
      horizontalBinEnable <= 1'b0;
      verticalBinEnable <= 1'b0;
      binCombine2x2 <= 1'b0;
      converter12Bit <= 1'b1;
      outputWord12Bit <= 1'b1;
      laneRateMbps <= 12'h000;
      gainCode <= 9'h000;
      cropParamError <= 1'b0;
    end else begin
      standbyOn <= standbyOn_next;
      timingRun <= timingRun_next;
      slaveMode <= !master;
      cropEnable <= cropEnable_next;
      horizontalBinEnable <= hBin_next;
      verticalBinEnable <= vBin_next;
      binCombine2x2 <= bin2x2_next;
      converter12Bit <= conv12_next;
      outputWord12Bit <= out12_next;
      laneRateMbps <= laneRate_next;
      gainCode <= gain_next;
      cropParamError <= cropErr_next;
    end
  end

  // Sync pins
  srcr_sync_pin u_vsync (
    .clk(core_clk),
    .rstN(rstN_reg),
    .master(master),
    .pinFunction(actByte[srcr_pkg::IX_SYFN][1:0]),
    .pinDrive(actByte[srcr_pkg::IX_SYDRV][1:0]),
    .genLevel(vsyncGen),
    .pinIn(vsyncPinIn),
    .pinOut(vsyncPinOut),
    .pinOe(vsyncPinOe),
    .pinSample(vsyncSample)
  );

  srcr_sync_pin u_hsync (
    .clk(core_clk),
    .rstN(rstN_reg),
    .master(master),
    .pinFunction(actByte[srcr_pkg::IX_SYFN][3:2]),
    .pinDrive(actByte[srcr_pkg::IX_SYDRV][3:2]),
    .genLevel(hsyncGen),
    .pinIn(hsyncPinIn),
    .pinOut(hsyncPinOut),
    .pinOe(hsyncPinOe),
    .pinSample(hsyncSample)
  );

endmodule
`default_nettype wire

/* srcr_regs_properties.sv */
// Checker for the sensor readout control register bank
`timescale 1ns/1ps
`default_nettype none
module srcr_regs_properties (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Inputs of the bank
  input wire logic regWrEn,
  input wire logic [15:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic frameReflect,
  input wire logic vsyncGen,
  input wire logic hsyncGen,
  // Outputs of the bank
  input wire logic vsyncPinOut,
  input wire logic hsyncPinOut,
  input wire logic standbyOn,
  input wire logic timingRun,
  input wire logic slaveMode,
  input wire logic cropEnable,
  input wire logic [19:0] frameLineCount,
  input wire logic converter12Bit,
  input wire logic outputWord12Bit,
  input wire logic [3:0] serialRateSelect,
  input wire logic [11:0] laneRateMbps,
  input wire logic [8:0] gainCode
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  run_stop_a: assert property (regWrEn && regAddr == 16'h3002 && regWrData[0] |-> ##2 !timingRun)
    else $error("timing runs after stop");
  crop_frame_a: assert property ($rose(cropEnable) |-> $past(frameReflect, 2))
    else $error("crop mode changed off frame point");
  lines_frame_a: assert property ($changed(frameLineCount) |-> $past(frameReflect))
    else $error("frame lines changed off frame point");
  rate_stby_a: assert property ($changed(serialRateSelect) |-> !standbyOn)
    else $error("rate changed in standby");
  rate_code_a: assert property (serialRateSelect == 4'h0 && $past(serialRateSelect) == 4'h0
    |-> laneRateMbps == 12'h948)
    else $error("rate code 0 decode wrong");
  vsync_out_a: assert property (vsyncPinOut |-> $past(vsyncGen))
    else $error("vertical sync pin high without sync");
  hsync_out_a: assert property (hsyncPinOut |-> $past(hsyncGen))
    else $error("horizontal sync pin high without sync");
  depth_stby_a: assert property ($changed(converter12Bit) || $changed(outputWord12Bit)
    |-> !standbyOn)
    else $error("depth changed in standby");
  role_stby_a: assert property ($changed(slaveMode) |-> !standbyOn)
    else $error("role changed in standby");
  gain_cap_a: assert property (gainCode <= 9'h0f0)
    else $error("gain above top step");
endmodule
bind srcr_regs srcr_regs_properties props (.core_clk, .reset_n, .regWrEn, .regAddr, .regWrData,
  .frameReflect, .vsyncGen, .hsyncGen, .vsyncPinOut, .hsyncPinOut, .standbyOn, .timingRun,
  .slaveMode, .cropEnable, .frameLineCount, .converter12Bit, .outputWord12Bit,
  .serialRateSelect, .laneRateMbps, .gainCode);
`default_nettype wire

/* srcr_host_model.sv */
// Host side of the byte register port
`timescale 1ns/1ps
`default_nettype none
module srcr_host_model (
  // Clock
  input wire logic core_clk,
  // Register port
  output logic regWrEn,
  output logic regRdEn,
  output logic [15:0] regAddr,
  output logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  input wire logic regRdValid
);
  initial begin
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 16'h0000;
    regWrData = 8'h00;
  end
  // Byte write; callers may set fixed bits, the bank keeps them at their fixed values
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWrEn <= 1'b0;
    regAddr <= ~a;
    regWrData <= ~d;
  endtask
  // Byte read; data and valid taken one cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
    @(posedge core_clk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRdEn <= 1'b0;
    regAddr <= ~a;
    @(posedge core_clk);
    d = regRdData;
    v = regRdValid;
  endtask
endmodule
`default_nettype wire

/* tb_sensor_readout_control_regs.sv */
// Self-checking testbench for the sensor readout control register bank
`timescale 1ns/1ps
`default_nettype none
module tb_sensor_readout_control_regs;
  logic core_clk, reset_n, regWrEn, regRdEn, regRdValid, frameReflect, farLevel;
  logic vsyncGen, hsyncGen, vsyncPinIn, hsyncPinIn, vsyncSample, hsyncSample;
  logic vsyncPinOut, vsyncPinOe, hsyncPinOut, hsyncPinOe;
  logic standbyOn, timingRun, slaveMode, cropEnable, cropParamError;
  logic horizontalBinEnable, verticalBinEnable, binCombine2x2, horizontalMirror, verticalFlip;
  logic converter12Bit, outputWord12Bit;
  logic [15:0] regAddr, lineClockCount;
  logic [7:0] regWrData, regRdData;
  logic [9:0] firstWaitTime, secondWaitTime;
  logic [19:0] frameLineCount, storageTime;
  logic [12:0] cropHorizontalStart, cropHorizontalWidth, cropVerticalStart, cropVerticalHeight;
  logic [3:0] serialRateSelect;
  logic [11:0] laneRateMbps;
  logic [8:0] gainCode;
  int n_errors, comparisons;
  // Pin level: own drive when enabled, else the far side
  assign vsyncPinIn = vsyncPinOe ? vsyncPinOut : farLevel;
  assign hsyncPinIn = hsyncPinOe ? hsyncPinOut : farLevel;
  srcr_regs dut (.core_clk, .reset_n, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData,
    .regRdValid, .frameReflect, .vsyncGen, .hsyncGen, .vsyncPinIn, .vsyncPinOut, .vsyncPinOe,
    .vsyncSample, .hsyncPinIn, .hsyncPinOut, .hsyncPinOe, .hsyncSample, .standbyOn, .timingRun,
    .slaveMode, .firstWaitTime, .secondWaitTime, .cropEnable, .horizontalBinEnable,
    .verticalBinEnable, .binCombine2x2, .horizontalMirror, .verticalFlip, .cropParamError,
    .frameLineCount, .lineClockCount, .cropHorizontalStart, .cropHorizontalWidth,
    .cropVerticalStart, .cropVerticalHeight, .converter12Bit, .outputWord12Bit,
    .serialRateSelect, .laneRateMbps, .storageTime, .gainCode);
  srcr_host_model host (.core_clk, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData,
    .regRdValid);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wrall(input logic [23:0] s[$]);
    foreach (s[i]) host.wr(s[i][23:8], s[i][7:0]);
  endtask
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Reset values of every byte and of the applied fields
  task automatic t_reset();
    logic [7:0] d;
    logic v;
    for (int i = 0; i < srcr_pkg::NUM_REGS; i++) begin
      host.rd(srcr_pkg::REG_ADDR[i], d, v);
      chk("read valid", v, 1'b1);
      chk("reset byte", d, srcr_pkg::REG_RST[i]);
    end
    host.rd(16'h3004, d, v);
    chk("unmapped", d, 8'h00);
    chk("lines", frameLineCount, 20'h008ca);
    chk("clocks", lineClockCount, 16'h0226);
    chk("waits", {firstWaitTime, secondWaitTime}, {10'h0ff, 10'h0b6});
    chk("crop", {cropHorizontalWidth, cropVerticalHeight}, {13'h0f18, 13'h1120});
    chk("storage", storageTime, 20'h00066);
    chk("depth", {converter12Bit, outputWord12Bit, serialRateSelect}, 6'h34);
    chk("rate", laneRateMbps, 12'h6f6);
    chk("idle", {timingRun, slaveMode, vsyncPinOe, hsyncPinOe, gainCode}, 13'h0);
    chk("pin sample", {vsyncSample, hsyncSample}, 2'b11);
  endtask
  // All ones written; fixed bits read back at their fixed value
  task automatic t_mask();
    logic [7:0] d;
    logic v;
    logic [7:0] m;
    for (int i = 0; i < srcr_pkg::NUM_REGS; i++) begin
      host.wr(srcr_pkg::REG_ADDR[i], 8'hff);
      host.rd(srcr_pkg::REG_ADDR[i], d, v);
      m = srcr_pkg::REG_MASK[i];
      chk("masked byte", d, m | (srcr_pkg::REG_RST[i] & ~m));
      host.wr(srcr_pkg::REG_ADDR[i], srcr_pkg::REG_RST[i]);
    end
  endtask
  // Standby bytes wait for release; then run, sync pins and slave role
  task automatic t_standby();
    wrall('{24'h303300, 24'h303100, 24'h303200, 24'h302001, 24'h302101, 24'h302201,
      24'h30c100, 24'h30083c});
    cyc(4);
    chk("held rate", serialRateSelect, 4'h4);
    host.wr(16'h3000, 8'h00);
    cyc(4);
    chk("rate", {serialRateSelect, laneRateMbps}, {4'h0, 12'h948});
    chk("depth", {converter12Bit, outputWord12Bit}, 2'b00);
    chk("binning", {horizontalBinEnable, verticalBinEnable, binCombine2x2}, 3'b111);
    chk("wait", firstWaitTime, 10'h03c);
    chk("pin drive", {vsyncPinOe, hsyncPinOe}, 2'b11);
    host.wr(16'h3002, 8'h00);
    cyc(3);
    chk("run", timingRun, 1'b1);
    vsyncGen <= 1'b1;
    hsyncGen <= 1'b1;
    cyc(3);
    chk("sync out", {vsyncPinOut, hsyncPinOut}, 2'b11);
    chk("sync sample", {vsyncSample, hsyncSample}, 2'b11);
    host.wr(16'h30c0, 8'h20);
    cyc(3);
    chk("sync low", {vsyncPinOut, hsyncPinOut}, 2'b00);
    chk("low sample", {vsyncSample, hsyncSample}, 2'b00);
    wrall('{24'h300201, 24'h30c02a, 24'h300001, 24'h300301, 24'h300000});
    cyc(4);
    chk("slave", {timingRun, slaveMode, vsyncPinOut}, 3'b010);
  endtask
  task automatic pulse();
    @(posedge core_clk);
    frameReflect <= 1'b1;
    @(posedge core_clk);
    frameReflect <= 1'b0;
    cyc(3);
  endtask
  // Frame bytes wait for the reflection point and for the hold to clear
  task automatic t_frame();
    wrall('{24'h300101, 24'h302434, 24'h302512, 24'h302605, 24'h301c04, 24'h309aff,
      24'h3090ff, 24'h309101, 24'h303003, 24'h302801, 24'h305077});
    wrall('{24'h304010, 24'h304230, 24'h304300, 24'h304408, 24'h304640, 24'h304700});
    pulse();
    chk("held lines", frameLineCount, 20'h008ca);
    host.wr(16'h3001, 8'h00);
    pulse();
    chk("lines", frameLineCount, 20'h51234);
    chk("crop", {cropEnable, cropParamError}, 2'b10);
    chk("crop h", {cropHorizontalStart, cropHorizontalWidth}, {13'h0010, 13'h0030});
    chk("crop v", {cropVerticalStart, cropVerticalHeight}, {13'h0008, 13'h0040});
    chk("gain", gainCode, 9'h0f0);
    chk("invert", {horizontalMirror, verticalFlip}, 2'b11);
    chk("line clocks", lineClockCount, 16'h0201);
    chk("storage", storageTime, 20'h00077);
    host.wr(16'h3040, 8'h11);
    pulse();
    chk("crop error", {cropParamError, cropHorizontalStart}, {1'b1, 13'h0011});
  endtask
  initial begin
    reset_n = 1'b0;
    frameReflect = 1'b0;
    vsyncGen = 1'b0;
    hsyncGen = 1'b0;
    farLevel = 1'b1;
    n_errors = 0;
    comparisons = 0;
    cyc(5);
    reset_n <= 1'b1;
    cyc(4);
    t_reset();
    t_mask();
    t_standby();
    t_frame();
    close_out();
  end
  initial begin
    #100us;
    n_errors++;
    close_out();
  end
endmodule
`default_nettype wire
